/* File: testbench.sv */
// Self-checking bench for the OTG configuration and event block
// Assumes uot_core with shortened frame counts and the far-end model
`timescale 1ns/100ps
`include "uot_regs.svh"

module testbench;
  import uot_pkg::*;
  localparam int        MS   = 300;
  localparam int        BITC = 9;
  localparam uot_addr_t A_TH = `UOT_OFS_THRESH;
  localparam uot_addr_t A_C1 = `UOT_OFS_CFG1;
  localparam uot_addr_t A_C2 = `UOT_OFS_CFG2;
  localparam uot_addr_t A_FL = `UOT_OFS_FLAGS;
  localparam uot_addr_t A_EN = `UOT_OFS_ENABLES;
  localparam uot_addr_t A_CT = `UOT_OFS_CTRL;
  logic       clk = 1'b0, rst_n = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0, idle = 1'b0, pdir = 1'b0;
  logic [3:0] sel = 4'h0, pep = 4'h0;
  uot_addr_t  adr = 8'h00;
  uot_word_t  dw = 32'h0000_0000, dr;
  uot_pp_t    ppm;
  logic       ack, id, se0, drx, dp, dm, vas, vbs, vav, paired, txdp, txdm, txoen, mon_n, pull, run, sof, sth, irq;
  int         mismatches = 0, checks = 0, now = 0;

  uot_core #(.MS_CYCLES(MS), .BYTE_CYCLES(1), .BIT_CYCLES(BITC)) i_dut (
    .CLK(clk), .RST_N(rst_n), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr),
    .WB_SEL_I(sel), .WB_DAT_I(dw), .WB_DAT_O(dr), .WB_ACK_O(ack), .CPU_IDLE(idle), .ID_IN(id),
    .SE0_IN(se0), .DIFF_RX_IN(drx), .DP_IN(dp), .DM_IN(dm), .VA_SESS_END_IN(vas),
    .VB_SESS_END_IN(vbs), .VA_VBUS_VLD_IN(vav), .PP_EP_IN(pep), .PP_DIR_OUT_IN(pdir),
    .PP_PAIRED(paired), .PINGPONG_MODE(ppm), .TX_DP(txdp), .TX_DM(txdm), .TX_OE_N(txoen),
    .DRIVE_MON_N(mon_n), .VBUS_PULLUP(pull), .MODULE_RUN(run), .SOF_TOKEN(sof),
    .SOF_THRESH(sth), .OTG_IRQ(irq));

  uot_far_end i_far (.tx_dp(txdp), .tx_dm(txdm), .tx_oe_n(txoen), .id(id), .se0(se0), .diff_rx(drx),
    .dp(dp), .dm(dm), .va_sess_end(vas), .vb_sess_end(vbs), .va_vbus_vld(vav));

  // ============================================================
  // Clock, cycle count, watchdog
  initial begin
    forever #5 clk = ~clk;
  end

  always @(posedge clk) now <= now + 1;

  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    tally_and_finish();
  end

  // ============================================================
  // Shared tasks
  task automatic check(input uot_word_t seen, input uot_word_t exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wb(input logic w, input uot_addr_t a, input uot_word_t d, input logic [3:0] s,
                    output uot_word_t q);
    int n;
    n = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dw <= d;
    sel <= s;
    while (ack !== 1'b1 && n++ < 20) @(posedge clk);
    q = dr;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (n >= 20) check(32'h0000_0000, 32'h0000_0001);
    @(posedge clk);
  endtask

  task automatic wr(input uot_addr_t a, input uot_word_t d);
    uot_word_t q;
    wb(1'b1, a, d, 4'hF, q);
  endtask

  task automatic rd(input uot_addr_t a, input uot_word_t m, input uot_word_t exp);
    uot_word_t q;
    wb(1'b0, a, 32'h0000_0000, 4'hF, q);
    check(q & m, exp);
  endtask

  // ============================================================
  // Scenarios
  task automatic t_reset();
    for (int a = 0; a <= 'h18; a += 4) rd(8'(a), 32'hFFFF_FFFF, 32'h0000_0000);
    $display("reset values done");
  endtask

  task automatic t_regs();
    uot_addr_t  ofs [4] = '{A_TH, A_C1, A_C2, A_EN};
    logic [7:0] msk [4] = '{8'hFF, 8'hD3, 8'h10, 8'hFD};
    uot_word_t  q;
    for (int i = 0; i < 4; i++) wr(ofs[i], 32'hFFFF_FFFF);
    for (int i = 0; i < 4; i++) rd(ofs[i], 32'hFFFF_FFFF, {24'h00_0000, msk[i]});
    check(32'(pull), 32'h0000_0001);
    wr(A_FL, 32'h0000_00FF);
    rd(A_FL, 32'hFFFF_FFFF, 32'h0000_0000);
    wb(1'b1, A_EN, 32'h0000_0000, 4'h0, q);
    rd(A_EN, 32'hFFFF_FFFF, 32'h0000_00FD);
    wr(8'h18, 32'hFFFF_FFFF);
    rd(8'h18, 32'hFFFF_FFFF, 32'h0000_0000);
    for (int i = 0; i < 4; i++) wr(ofs[i], 32'h0000_0000);
    check(32'(pull), 32'h0000_0000);
    wr(A_TH, 32'h0000_004A);
    rd(A_TH, 32'hFFFF_FFFF, 32'h0000_004A);
    $display("register access done");
  endtask

  task automatic t_pingpong();
    logic exp;
    for (int m = 0; m < 4; m++) begin
      wr(A_C1, 32'(m));
      check(32'(ppm), 32'(m));
      for (int e = 0; e < 16; e += 15) begin
        for (int d = 0; d < 2; d++) begin
          pep <= 4'(e);
          pdir <= d[0];
          @(posedge clk);
          exp = (m == 2) || (m == 3 && e != 0) || (m == 1 && e == 0 && d == 1);
          check(32'(paired), 32'(exp));
        end
      end
    end
    $display("ping-pong layouts done");
  endtask

  task automatic t_run();
    wr(A_CT, 32'h0000_0001);
    wr(A_C1, 32'h0000_0010);
    check(32'(run), 32'h0000_0001);
    idle <= 1'b1;
    @(posedge clk);
    check(32'(run), 32'h0000_0000);
    i_far.set_id(1'b0);
    repeat (4) @(posedge clk);
    rd(A_FL, 32'h0000_0080, 32'h0000_0000);
    idle <= 1'b0;
    @(posedge clk);
    check(32'(run), 32'h0000_0001);
    wr(A_C1, 32'h0000_0000);
    wr(A_FL, 32'h0000_00FF);
    $display("halt in idle done");
  endtask

  task automatic t_events();
    uot_word_t bitv [3] = '{32'h0000_0008, 32'h0000_0004, 32'h0000_0001};
    wr(A_EN, 32'h0000_0080);
    i_far.set_id(1'b1);
    repeat (3) @(posedge clk);
    check(32'(irq), 32'h0000_0001);
    rd(A_FL, 32'h0000_008F, 32'h0000_0080);
    wr(A_FL, 32'h0000_0000);
    rd(A_FL, 32'h0000_0080, 32'h0000_0080);
    wr(A_EN, 32'h0000_0000);
    check(32'(irq), 32'h0000_0000);
    wr(A_FL, 32'h0000_0080);
    rd(A_FL, 32'h0000_0080, 32'h0000_0000);
    for (int b = 0; b < 3; b++) begin
      for (int lv = 1; lv >= 0; lv--) begin
        i_far.set_vbus(b, lv[0]);
        repeat (3) @(posedge clk);
        rd(A_FL, 32'h0000_000F, bitv[b]);
        wr(A_FL, bitv[b]);
      end
    end
    $display("pin events done");
  endtask

  task automatic t_line();
    wr(A_FL, 32'h0000_00FF);
    i_far.set_se0(1'b1);
    repeat (3) @(posedge clk);
    rd(A_FL, 32'h0000_0010, 32'h0000_0010);
    wr(A_FL, 32'h0000_00FF);
    repeat (200) @(posedge clk);
    rd(A_FL, 32'h0000_0020, 32'h0000_0000);
    repeat (120) @(posedge clk);
    rd(A_FL, 32'h0000_0020, 32'h0000_0020);
    i_far.set_se0(1'b0);
    wr(A_FL, 32'h0000_00FF);
    $display("activity and line state done");
  endtask

  task automatic t_timer();
    int n, t0;
    n = 0;
    wr(A_EN, 32'h0000_0040);
    wr(A_FL, 32'h0000_0040);
    while (irq !== 1'b1 && n++ < 400) @(posedge clk);
    t0 = now;
    wr(A_FL, 32'h0000_0040);
    check(32'(irq), 32'h0000_0000);
    n = 0;
    while (irq !== 1'b1 && n++ < 400) @(posedge clk);
    check(32'(now - t0), 32'(MS));
    wr(A_EN, 32'h0000_0000);
    $display("millisecond timer done");
  endtask

  task automatic t_frame();
    int n, t0, t1;
    n = 0;
    wr(A_TH, 32'h0000_0012);
    wr(A_CT, 32'h0000_000D);
    while (sof !== 1'b1 && n++ < 400) @(posedge clk);
    t0 = now;
    @(posedge clk);
    n = 0;
    while (sth !== 1'b1 && n++ < 400) @(posedge clk);
    t1 = now;
    n = 0;
    while (sof !== 1'b1 && n++ < 400) @(posedge clk);
    check(32'(now - t0), 32'(MS));
    check(32'(now - t1), 32'h0000_0012);
    wr(A_CT, 32'h0000_0001);
    $display("frame timing done");
  endtask

  task automatic t_eye();
    int   n;
    logic v;
    n = 0;
    wr(A_C1, 32'h0000_0080);
    @(posedge clk);
    check(32'(txoen), 32'h0000_0000);
    v = txdp;
    while (txdp === v && n++ < 40) @(posedge clk);
    v = txdp;
    check(32'(txdm ^ v), 32'h0000_0001);
    repeat (BITC - 1) @(posedge clk);
    check(32'(txdp ^ v), 32'h0000_0000);
    @(posedge clk);
    check(32'(txdp ^ v), 32'h0000_0001);
    wr(A_C1, 32'h0000_00C0);
    check(32'(mon_n), 32'h0000_0001);
    wr(A_CT, 32'h0000_0003);
    check(32'(mon_n), 32'h0000_0000);
    wr(A_C1, 32'h0000_0040);
    @(posedge clk);
    check(32'({txoen, mon_n}), 32'h0000_0003);
    wr(A_CT, 32'h0000_0001);
    wr(A_C1, 32'h0000_0000);
    $display("eye pattern and monitor done");
  endtask

  // ============================================================
  // Verdict and main sequence
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_regs();
    t_pingpong();
    t_run();
    t_events();
    t_line();
    t_timer();
    t_frame();
    t_eye();
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    tally_and_finish();
  end
endmodule

/* File: uot_core.sv */
// OTG configuration registers, OTG event flags and host frame timing
// Assumes a classic Wishbone master and pins synchronous to CLK
//
// Contract
// - Threshold field holds ten plus packet bytes; host checks frame time left.
// - Eye test bit set drives the eye pattern on the lines.
// - Monitor bit set drives active-low drive enable onto monitor output.
// - Monitor bit acts only while transceiver disable is set.
// - Halt-in-idle set stops the module while processor is idle.
// - Ping-pong field selects which endpoints get even/odd descriptors.
// - VBUS pull-up follows its control bit.
// - Bits 15 to 8 of each register read zero.
// - ID level change sets the ID flag.
// - Each one millisecond timer expiry sets the timer flag.
// - Line state stable 1 ms and new sets the line flag.
// - Activity on D+, D- or VBUS sets the activity flag.
// - A-session-end crossing sets the session valid flag.
// - B-session-end crossing sets the B-device flag.
// - A-VBUS-valid crossing sets bit 0; bit 1 reads zero.
// - Threshold flags set on both rising and falling crossings.
// - Flags clear only on written one; zero leaves them.
// - Each flag has a matching enable bit.
// - Host threshold reach within frame pulses the frame flag; here it only pulses SOF_THRESH, and no flag bit is set.
// - J-state is differential zero low speed, one full speed.
// - Host with frame tokens enabled sends one every millisecond.
//
// Decided for this implementation: the Wishbone slave port and the register addresses.
`timescale 1ns/100ps
`include "uot_regs.svh"

module uot_core #(
  parameter int MS_CYCLES   = `UOT_MS_CYCLES,
  parameter int BYTE_CYCLES = `UOT_BYTE_CYCLES,
  parameter int BIT_CYCLES  = `UOT_BIT_CYCLES
) (
  input  wire logic              CLK,
  input  wire logic              RST_N,
  input  wire logic              WB_CYC_I,
  input  wire logic              WB_STB_I,
  input  wire logic              WB_WE_I,
  input  wire uot_pkg::uot_addr_t WB_ADR_I,
  input  wire logic [3:0]        WB_SEL_I,
  input  wire uot_pkg::uot_word_t WB_DAT_I,
  output      uot_pkg::uot_word_t WB_DAT_O,
  output      logic              WB_ACK_O,
  input  wire logic              CPU_IDLE,
  input  wire logic              ID_IN,
  input  wire logic              SE0_IN,
  input  wire logic              DIFF_RX_IN,
  input  wire logic              DP_IN,
  input  wire logic              DM_IN,
  input  wire logic              VA_SESS_END_IN,
  input  wire logic              VB_SESS_END_IN,
  input  wire logic              VA_VBUS_VLD_IN,
  input  wire logic [3:0]        PP_EP_IN,
  input  wire logic              PP_DIR_OUT_IN,
  output      logic              PP_PAIRED,
  output      uot_pkg::uot_pp_t  PINGPONG_MODE,
  output      logic              TX_DP,
  output      logic              TX_DM,
  output      logic              TX_OE_N,
  output      logic              DRIVE_MON_N,
  output      logic              VBUS_PULLUP,
  output      logic              MODULE_RUN,
  output      logic              SOF_TOKEN,
  output      logic              SOF_THRESH,
  output      logic              OTG_IRQ
);
  import uot_pkg::*;

  // ============================================================
  // Parameter checks
  if (MS_CYCLES < 16 || MS_CYCLES > 2**24) begin : g_ms_chk
    $error("MS_CYCLES out of range");
  end
  if (BYTE_CYCLES < 1 || BIT_CYCLES < 1) begin : g_byte_chk
    $error("BYTE_CYCLES and BIT_CYCLES must be positive");
  end
  if (MS_CYCLES <= 255 * BYTE_CYCLES) begin : g_frame_chk
    $error("Frame too short for threshold range");
  end

  localparam logic [23:0] MS_LAST = 24'(MS_CYCLES - 1);
  localparam logic [23:0] BYTE_C  = 24'(BYTE_CYCLES);
  localparam logic [7:0]  BIT_LAST = 8'(BIT_CYCLES - 1);

  // ============================================================
  // Functions
  function automatic logic pp_pair(uot_pp_t m, logic [3:0] ep, logic dout);
    case (m)
      UOT_PP_EP1_15: pp_pair = (ep != 4'h0);
      UOT_PP_ALL:    pp_pair = 1'b1;
      UOT_PP_EP0OUT: pp_pair = (ep == 4'h0) && dout;
      default:       pp_pair = 1'b0;
    endcase
  endfunction

  function automatic uot_word_t rd_byte(uot_byte_t v);
    rd_byte = {24'h00_0000, v};
  endfunction

  // ============================================================
  // Registers
  uot_byte_t  thresh_reg;
  uot_byte_t  cfg1_reg;
  uot_byte_t  cfg2_reg;
  uot_byte_t  flags_reg;
  uot_byte_t  flags_next;
  uot_byte_t  enables_reg;
  uot_byte_t  ctrl_reg;
  logic       ack_reg;
  uot_word_t  dat_reg;

  logic       req;
  logic       wr_fire;
  logic       lane0;
  uot_byte_t  wbyte;

  assign req     = WB_CYC_I && WB_STB_I;
  assign wr_fire = req && WB_WE_I && ack_reg;
  assign lane0   = WB_SEL_I[0];
  assign wbyte   = WB_DAT_I[7:0];

  // ============================================================
  // Wishbone handshake
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= req && !ack_reg;
    end
  end

  assign WB_ACK_O = ack_reg;

  // ============================================================
  // Read data
  uot_word_t rd_mux;
  always_comb begin
    if (WB_ADR_I == `UOT_OFS_THRESH) begin
      rd_mux = rd_byte(thresh_reg);
    end else if (WB_ADR_I == `UOT_OFS_CFG1) begin
      rd_mux = rd_byte(cfg1_reg);
    end else if (WB_ADR_I == `UOT_OFS_CFG2) begin
      rd_mux = rd_byte(cfg2_reg);
    end else if (WB_ADR_I == `UOT_OFS_FLAGS) begin
      rd_mux = rd_byte(flags_reg);
    end else if (WB_ADR_I == `UOT_OFS_ENABLES) begin
      rd_mux = rd_byte(enables_reg);
    end else if (WB_ADR_I == `UOT_OFS_CTRL) begin
      rd_mux = rd_byte(ctrl_reg);
    end else begin
      rd_mux = 32'h0000_0000;
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      dat_reg <= 32'h0000_0000;
    end else if (req && !ack_reg && !WB_WE_I) begin
      dat_reg <= rd_mux;
    end
  end

  assign WB_DAT_O = dat_reg;

  // ============================================================
  // Configuration writes
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      thresh_reg <= `UOT_RST_BYTE;
    end else if (wr_fire && lane0 && WB_ADR_I == `UOT_OFS_THRESH) begin
      thresh_reg <= wbyte;
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      cfg1_reg <= `UOT_RST_BYTE;
    end else if (wr_fire && lane0 && WB_ADR_I == `UOT_OFS_CFG1) begin
      cfg1_reg <= wbyte & `UOT_MASK_CFG1;
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      cfg2_reg <= `UOT_RST_BYTE;
    end else if (wr_fire && lane0 && WB_ADR_I == `UOT_OFS_CFG2) begin
      cfg2_reg <= wbyte & `UOT_MASK_CFG2;
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      enables_reg <= `UOT_RST_BYTE;
    end else if (wr_fire && lane0 && WB_ADR_I == `UOT_OFS_ENABLES) begin
      enables_reg <= wbyte & `UOT_MASK_FLAGS;
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      ctrl_reg <= `UOT_RST_BYTE;
    end else if (wr_fire && lane0 && WB_ADR_I == `UOT_OFS_CTRL) begin
      ctrl_reg <= wbyte & `UOT_MASK_CTRL;
    end
  end

  // ============================================================
  // Control decode
  logic run;
  logic host_sof;
  logic eye_on;

  assign run      = ctrl_reg[`UOT_CTRL_PWR] &&
                    !(cfg1_reg[`UOT_CFG1_HALT] && CPU_IDLE);
  assign host_sof = run && ctrl_reg[`UOT_CTRL_HOST] && ctrl_reg[`UOT_CTRL_SOF];
  assign eye_on   = run && cfg1_reg[`UOT_CFG1_EYE];
  assign MODULE_RUN    = run;
  assign VBUS_PULLUP   = cfg2_reg[`UOT_CFG2_PULLUP];
  assign PINGPONG_MODE = uot_pp_t'(cfg1_reg[1:0]);
  assign PP_PAIRED     = pp_pair(uot_pp_t'(cfg1_reg[1:0]), PP_EP_IN, PP_DIR_OUT_IN);

  // ============================================================
  // Millisecond and frame timer
  logic [23:0] ms_cnt;
  logic        ms_tick;
  logic [23:0] thresh_cyc;

  assign ms_tick    = run && (ms_cnt == MS_LAST);
  assign thresh_cyc = 24'(thresh_reg) * BYTE_C;

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      ms_cnt <= 24'h00_0000;
    end else if (!run) begin
      ms_cnt <= ms_cnt;
    end else if (ms_tick) begin
      ms_cnt <= 24'h00_0000;
    end else begin
      ms_cnt <= ms_cnt + 24'h00_0001;
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      SOF_TOKEN  <= 1'b0;
      SOF_THRESH <= 1'b0;
    end else begin
      SOF_TOKEN  <= host_sof && ms_tick;
      SOF_THRESH <= host_sof && (MS_LAST - ms_cnt == thresh_cyc);
    end
  end

  // ============================================================
  // Eye pattern generator
  logic [7:0] bit_cnt;
  logic       eye_bit;

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      bit_cnt <= 8'h00;
      eye_bit <= 1'b0;
    end else if (!eye_on) begin
      bit_cnt <= 8'h00;
      eye_bit <= 1'b0;
    end else if (bit_cnt == BIT_LAST) begin
      bit_cnt <= 8'h00;
      eye_bit <= !eye_bit;
    end else begin
      bit_cnt <= bit_cnt + 8'h01;
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      TX_DP   <= 1'b1;
      TX_DM   <= 1'b0;
      TX_OE_N <= 1'b1;
    end else begin
      TX_DP   <= eye_on ? eye_bit : 1'b1;
      TX_DM   <= eye_on ? !eye_bit : 1'b0;
      TX_OE_N <= !eye_on;
    end
  end

  assign DRIVE_MON_N = (cfg1_reg[`UOT_CFG1_MON] && ctrl_reg[`UOT_CTRL_TRDIS]) ?
                       TX_OE_N : 1'b1;

  // ============================================================
  // Event detection
  logic      j_now;
  uot_line_t line_now;
  uot_line_t line_prev;
  uot_line_t line_rep;
  logic [23:0] line_cnt;
  logic      line_evt;
  logic [6:0] pin_prev;
  logic [6:0] pin_now;
  logic      pins_valid;

  assign j_now    = ctrl_reg[`UOT_CTRL_LSPD] ? !DIFF_RX_IN : DIFF_RX_IN;
  assign line_now = {SE0_IN, j_now};
  assign pin_now  = {ID_IN, DP_IN, DM_IN, VA_SESS_END_IN, VB_SESS_END_IN,
                     VA_VBUS_VLD_IN, 1'b0};

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      pin_prev   <= 7'h00;
      pins_valid <= 1'b0;
    end else begin
      pin_prev   <= pin_now;
      pins_valid <= 1'b1;
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      line_prev <= 2'b00;
      line_rep  <= 2'b00;
      line_cnt  <= 24'h00_0000;
    end else begin
      line_prev <= line_now;
      if (line_now != line_prev || !run) begin
        line_cnt <= 24'h00_0000;
      end else if (line_cnt != MS_LAST) begin
        line_cnt <= line_cnt + 24'h00_0001;
      end
      if (line_evt) begin
        line_rep <= line_prev;
      end
    end
  end

  assign line_evt = run && line_cnt == MS_LAST - 24'h00_0001 &&
                    line_now == line_prev && line_prev != line_rep;

  // ============================================================
  // Flags
  uot_byte_t hw_set;
  uot_byte_t sw_clr;
  logic      chg_id;
  logic      chg_act;

  assign chg_id  = pins_valid && (pin_now[6] != pin_prev[6]);
  assign chg_act = pins_valid && (pin_now[5:1] != pin_prev[5:1]);

  always_comb begin
    hw_set = 8'h00;
    if (run) begin
      hw_set[`UOT_FLAG_ID]   = chg_id;
      hw_set[`UOT_FLAG_MS]   = ms_tick;
      hw_set[`UOT_FLAG_LINE] = line_evt;
      hw_set[`UOT_FLAG_ACT]  = chg_act;
      hw_set[`UOT_FLAG_SESV] = pins_valid && (pin_now[3] ^ pin_prev[3]);
      hw_set[`UOT_FLAG_BEND] = pins_valid && (pin_now[2] ^ pin_prev[2]);
      hw_set[`UOT_FLAG_AVLD] = pins_valid && (pin_now[1] ^ pin_prev[1]);
    end
  end

  assign sw_clr = (wr_fire && lane0 && WB_ADR_I == `UOT_OFS_FLAGS) ? wbyte : 8'h00;
  assign flags_next = ((flags_reg & ~sw_clr) | hw_set) & `UOT_MASK_FLAGS;

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      flags_reg <= `UOT_RST_BYTE;
    end else begin
      flags_reg <= flags_next;
    end
  end

  assign OTG_IRQ = |(flags_reg & enables_reg);

  // ============================================================
  // Assertions
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);

  ack_one_a: assert property (ack_reg |=> !ack_reg)
    else $error("ack held two cycles");
  hi_zero_a: assert property (ack_reg && !WB_WE_I |-> WB_DAT_O[31:8] == 24'h00_0000)
    else $error("upper read bits not zero");
  bit1_zero_a: assert property (!flags_reg[1] && !enables_reg[1])
    else $error("bit 1 set");
  set_wins_a: assert property (|hw_set |=> (flags_reg & $past(hw_set)) == $past(hw_set))
    else $error("hardware set lost");
  clr_zero_a: assert property (!(|hw_set) && sw_clr == 8'h00 |=> $stable(flags_reg))
    else $error("flag changed without cause");
  clr_one_a: assert property (sw_clr[7] && !hw_set[7] |=> !flags_reg[7])
    else $error("write one did not clear");
  irq_map_a: assert property (OTG_IRQ == |(flags_reg & enables_reg))
    else $error("irq mismatch");
  id_flag_a: assert property (run && chg_id |=> flags_reg[`UOT_FLAG_ID])
    else $error("id change missed");
  vbus_a: assert property (run && pins_valid && $changed(VA_VBUS_VLD_IN) |=> flags_reg[0])
    else $error("vbus crossing missed");
  mon_a: assert property (!ctrl_reg[`UOT_CTRL_TRDIS] |-> DRIVE_MON_N)
    else $error("monitor active without transceiver disable");
  pull_a: assert property (VBUS_PULLUP == cfg2_reg[`UOT_CFG2_PULLUP])
    else $error("pullup mismatch");
  halt_a: assert property (cfg1_reg[`UOT_CFG1_HALT] && CPU_IDLE |-> !run ##1 $stable(ms_cnt))
    else $error("ran while idle");
  sof_a: assert property (SOF_TOKEN |-> ##1 !SOF_TOKEN [*8])
    else $error("frame token too soon");
  eye_a: assert property (eye_on && $past(eye_on) |=> !TX_OE_N && TX_DP != TX_DM)
    else $error("eye pattern not driven");

  wr_cov_c: cover property (wr_fire ##2 ack_reg);
  clr_cov_c: cover property (|sw_clr && |hw_set);
  sof_cov_c: cover property (SOF_THRESH ##[1:1000] SOF_TOKEN);
  line_cov_c: cover property (line_evt);

endmodule

/* File: uot_far_end.sv */
// Far-end USB party: ID pin, VBUS comparators and D+/D- levels
// Assumes its tasks are called right after a rising clock edge
`timescale 1ns/100ps

module uot_far_end (
  input  wire logic tx_dp,
  input  wire logic tx_dm,
  input  wire logic tx_oe_n,
  output logic      id,
  output logic      se0,
  output logic      diff_rx,
  output logic      dp,
  output logic      dm,
  output logic      va_sess_end,
  output logic      vb_sess_end,
  output logic      va_vbus_vld
);
  logic       id_reg   = 1'b1;
  logic       se0_reg  = 1'b0;
  logic [2:0] vbus_reg = 3'b000;

  // ============================================================
  // Line levels
  // Released D+ sits at its pull-up, D- at its pull-down
  assign dp          = tx_oe_n ? ~se0_reg : tx_dp;
  assign dm          = tx_oe_n ? 1'b0 : tx_dm;
  assign se0         = ~dp & ~dm;
  assign diff_rx     = dp & ~dm;
  assign id          = id_reg;
  assign va_sess_end = vbus_reg[0];
  assign vb_sess_end = vbus_reg[1];
  assign va_vbus_vld = vbus_reg[2];

  // ============================================================
  // Commands
  task automatic set_id(input logic v);
    id_reg <= v;
  endtask

  task automatic set_se0(input logic v);
    se0_reg <= v;
  endtask

  // Comparator crossings either way
  task automatic set_vbus(input int b, input logic v);
    vbus_reg[b] <= v;
  endtask
endmodule

/* File: uot_pkg.sv */
// Types shared by the OTG configuration block
// Assumes the register header is included alongside
package uot_pkg;

  // ============================================================
  // Ping-pong buffer layouts
  typedef enum logic [1:0] {
    UOT_PP_NONE   = 2'b00,
    UOT_PP_EP0OUT = 2'b01,
    UOT_PP_ALL    = 2'b10,
    UOT_PP_EP1_15 = 2'b11
  } uot_pp_t;

  typedef logic [7:0]  uot_byte_t;
  typedef logic [31:0] uot_word_t;
  typedef logic [7:0]  uot_addr_t;
  typedef logic [1:0]  uot_line_t;

endpackage

/* File: uot_regs.svh */
// Register map, field positions, reset values and timing counts
// Assumes a 100 MHz clock and a 32-bit classic Wishbone register bus
`ifndef UOT_REGS_SVH
`define UOT_REGS_SVH

// ============================================================
// Register byte offsets
`define UOT_OFS_THRESH   8'h00
`define UOT_OFS_CFG1     8'h04
`define UOT_OFS_CFG2     8'h08
`define UOT_OFS_FLAGS    8'h0C
`define UOT_OFS_ENABLES  8'h10
`define UOT_OFS_CTRL     8'h14

// ============================================================
// Field positions
`define UOT_CFG1_EYE     7
`define UOT_CFG1_MON     6
`define UOT_CFG1_HALT    4
`define UOT_CFG2_PULLUP  4
`define UOT_CTRL_PWR     0
`define UOT_CTRL_TRDIS   1
`define UOT_CTRL_HOST    2
`define UOT_CTRL_SOF     3
`define UOT_CTRL_LSPD    4
`define UOT_FLAG_ID      7
`define UOT_FLAG_MS      6
`define UOT_FLAG_LINE    5
`define UOT_FLAG_ACT     4
`define UOT_FLAG_SESV    3
`define UOT_FLAG_BEND    2
`define UOT_FLAG_AVLD    0

// ============================================================
// Writable masks and reset values
`define UOT_MASK_CFG1    8'hD3
`define UOT_MASK_CFG2    8'h10
`define UOT_MASK_FLAGS   8'hFD
`define UOT_MASK_CTRL    8'h1F
`define UOT_RST_BYTE     8'h00
`define UOT_THRESH_BASE  10

// ============================================================
// Timing
`define UOT_CLK_PERIOD_PS 10000
`define UOT_MS_TIME_PS    1000000000
`define UOT_BYTE_TIME_PS  666667
`define UOT_BIT_TIME_PS   83334
`define UOT_MS_CYCLES   (`UOT_MS_TIME_PS / `UOT_CLK_PERIOD_PS)
`define UOT_BYTE_CYCLES ((`UOT_BYTE_TIME_PS + `UOT_CLK_PERIOD_PS - 1) / `UOT_CLK_PERIOD_PS)
`define UOT_BIT_CYCLES  ((`UOT_BIT_TIME_PS + `UOT_CLK_PERIOD_PS - 1) / `UOT_CLK_PERIOD_PS)

`endif
